// >>> shared/snf_pkg.sv
// Purpose: Shared constants and types for the serial video line-coding path
// Assumes: One bit per ref_clk cycle on both serial sides
// Notes:   Character width is 10 bits, 8-bit video rides in the upper bits
package snf_pkg;

	localparam int          CHAR_W      = 10;
	localparam int          HIST_W      = 3 * CHAR_W;
	localparam int          SCR_LEN     = 9;
	localparam int          TAP_HI      = 8;
	localparam int          TAP_LO      = 3;
	localparam int          NARROW_W    = 8;
	localparam int          PAD_W       = CHAR_W - NARROW_W;
	localparam logic [3:0]  BIT_CNT_MAX = 4'h9;
	localparam logic [3:0]  BIT_CNT_ONE = 4'h1;
	localparam logic [3:0]  FILL_BITS   = 4'hA;
	localparam logic [1:0]  PAD_BITS    = 2'h0;
	localparam logic [9:0]  TRS_ONES    = 10'h3FF;
	localparam logic [9:0]  TRS_ZERO    = 10'h000;
	localparam logic [9:0]  RSV_LO_MAX  = 10'h003;
	localparam logic [9:0]  RSV_HI_MIN  = 10'h3FC;
	localparam logic [9:0]  IDLE_CHAR   = 10'h200;
	localparam logic [1:0]  BUF_DEPTH   = 2'h2;
	localparam logic [1:0]  CNT_ONE     = 2'h1;

	typedef struct packed {
		logic [9:0] data;
	} snf_word_t;

	typedef enum logic [1:0] {
		FR_HUNT   = 2'h1,
		FR_LOCKED = 2'h2
	} snf_frame_t;

endpackage : snf_pkg

// >>> logic/snf_line_coder.sv
// Purpose: Transmit scrambler/NRZI encoder and receive NRZI decoder/descrambler/framer
// Assumes: ref_clk is the bit clock; character rate is an enable pulse every ten bits
// Notes:   Serial inputs are synchronous to ref_clk, one bit per cycle
`timescale 1ns/1ns
`default_nettype none

module snf_line_coder
	import snf_pkg::*;
(
	input  wire logic        ref_clk,        // Bit clock, 50 MHz
	input  wire logic        rst_n,          // Asynchronous reset, active low
	input  wire logic        tx_valid,       // Source offers a character
	output logic             tx_ready,       // Buffer can take a character
	input  wire logic [9:0]  tx_data,        // Source character
	input  wire logic        tx_mode8,       // High: tx_data[7:0] is 8-bit video
	output logic             tx_char_stb,    // Transmit character-rate pulse
	output logic             tx_serial,      // NRZI encoded line bit
	input  wire logic        rx_serial,      // Recovered line bit
	output logic             rx_char_stb,    // Receive character-rate pulse
	output logic [9:0]       rx_data,        // Framed output character
	output logic             rx_data_valid,  // rx_data holds a valid character
	output logic             rx_aligned      // A reference sequence has been seen
);

	// Character mapping and reserved-range correction
	function automatic logic [9:0] map_char(input logic [9:0] d, input logic m8);
		logic [9:0] c;
		c = m8 ? {d[NARROW_W-1:0], PAD_BITS} : d;
		if (c <= RSV_LO_MAX)
			return TRS_ZERO;
		else if (c >= RSV_HI_MIN)
			return TRS_ONES;
		else
			return c;
	endfunction : map_char

	// Two-entry transmit buffer
	snf_word_t   buf_mem [0:1];
	logic        wr_ptr;
	logic        rd_ptr;
	logic [1:0]  buf_cnt;
	logic        buf_push;
	logic        buf_pop;
	logic        char_edge;
	snf_word_t   in_word;
	logic [3:0]  tx_cnt;

	assign tx_ready  = (buf_cnt != BUF_DEPTH);
	assign buf_push  = tx_valid && tx_ready;
	assign char_edge = (tx_cnt == BIT_CNT_MAX);
	assign buf_pop   = char_edge && (buf_cnt != 2'h0);
	assign in_word   = '{data: map_char(tx_data, tx_mode8)};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_buf
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n)
					buf_mem[gi] <= '0;
				else if (buf_push && (wr_ptr == 1'(gi)))
					buf_mem[gi] <= in_word;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr  <= 1'b0;
			rd_ptr  <= 1'b0;
			buf_cnt <= 2'h0;
		end else begin
			if (buf_push)
				wr_ptr <= ~wr_ptr;
			if (buf_pop)
				rd_ptr <= ~rd_ptr;
			if (buf_push && !buf_pop)
				buf_cnt <= buf_cnt + CNT_ONE;
			else if (buf_pop && !buf_push)
				buf_cnt <= buf_cnt - CNT_ONE;
		end
	end

	// Transmit character divider and serializer
	logic [CHAR_W-1:0]  tx_shift;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt      <= 4'h0;
			tx_char_stb <= 1'b0;
		end else begin
			tx_cnt      <= char_edge ? 4'h0 : tx_cnt + BIT_CNT_ONE;
			tx_char_stb <= char_edge;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			tx_shift <= IDLE_CHAR;
		else if (char_edge)
			tx_shift <= buf_pop ? buf_mem[rd_ptr].data : IDLE_CHAR;
		else
			tx_shift <= {1'b0, tx_shift[CHAR_W-1:1]};
	end

	// Scrambler then NRZI encoder
	logic [SCR_LEN-1:0] scr;
	logic               scr_bit;

	assign scr_bit = tx_shift[0] ^ scr[TAP_HI] ^ scr[TAP_LO];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			scr <= '0;
		else
			scr <= {scr[SCR_LEN-2:0], scr_bit};
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			tx_serial <= 1'b0;
		else
			tx_serial <= tx_serial ^ scr_bit;
	end

	// NRZI decoder
	logic rx_prev;
	logic nrz_bit;

	assign nrz_bit = rx_serial ^ rx_prev;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rx_prev <= 1'b0;
		else
			rx_prev <= rx_serial;
	end

	// Feed-forward descrambler
	logic [SCR_LEN-1:0] dsr;
	logic               desc_bit;

	assign desc_bit = nrz_bit ^ dsr[TAP_HI] ^ dsr[TAP_LO];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			dsr <= '0;
		else
			dsr <= {dsr[SCR_LEN-2:0], nrz_bit};
	end

	// Fill counter: descrambler history must be all received bits
	logic [3:0] fill_cnt;
	logic       filled;

	assign filled = (fill_cnt == FILL_BITS);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			fill_cnt <= 4'h0;
		else if (!filled)
			fill_cnt <= fill_cnt + BIT_CNT_ONE;
	end

	// Framer: history holds the last three characters, newest bit on top
	logic [HIST_W-1:0]  hist;
	logic [HIST_W-1:0]  next_hist;
	logic               trs_hit;
	logic [3:0]         rx_cnt;
	logic               rx_edge;
	snf_frame_t         fr_state;

	assign next_hist = {desc_bit, hist[HIST_W-1:1]};
	assign trs_hit   = (next_hist[CHAR_W-1:0] == TRS_ONES)
	                && (next_hist[2*CHAR_W-1:CHAR_W] == TRS_ZERO)
	                && (next_hist[HIST_W-1:2*CHAR_W] == TRS_ZERO);
	assign rx_edge   = (rx_cnt == BIT_CNT_MAX) || trs_hit;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			hist <= '0;
		else
			hist <= next_hist;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rx_cnt <= 4'h0;
		else if (rx_edge)
			rx_cnt <= 4'h0;
		else
			rx_cnt <= rx_cnt + BIT_CNT_ONE;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			fr_state <= FR_HUNT;
		else begin
			unique case (fr_state)
				FR_HUNT: begin
					if (trs_hit)
						fr_state <= FR_LOCKED;
				end
				FR_LOCKED: begin
					fr_state <= FR_LOCKED;
				end
				default: begin
					fr_state <= FR_HUNT;
				end
			endcase
		end
	end

	assign rx_aligned = (fr_state == FR_LOCKED);

	// Character output
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_char_stb   <= 1'b0;
			rx_data       <= '0;
			rx_data_valid <= 1'b0;
		end else begin
			rx_char_stb <= rx_edge;
			if (rx_edge) begin
				rx_data       <= next_hist[HIST_W-1:2*CHAR_W];
				rx_data_valid <= filled;
			end
		end
	end

endmodule : snf_line_coder

`default_nettype wire

// >>> testbench/snf_chk.sv
// Purpose: Port checker for the line coder
// Assumes: One clock, asynchronous active-low reset
// Notes:   Sees only top-level ports
`timescale 1ns/1ns
`default_nettype none
module snf_chk
	import snf_pkg::*;
(
	input wire logic       ref_clk,       // Bit clock
	input wire logic       rst_n,         // Reset, active low
	input wire logic       tx_valid,      // Source offer
	input wire logic       tx_ready,      // Buffer space
	input wire logic       tx_char_stb,   // Tx character pulse
	input wire logic       rx_char_stb,   // Rx character pulse
	input wire logic [9:0] rx_data,       // Rx character
	input wire logic       rx_data_valid, // Rx character valid
	input wire logic       rx_aligned     // Framer locked
);
	logic [3:0] fill;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			fill <= 4'h0;
		else if (fill != 4'hF)
			fill <= fill + 4'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_tx_period;
		tx_char_stb |=> !tx_char_stb [*8] ##1 !tx_char_stb ##1 tx_char_stb;
	endproperty
	a_tx_period: assert property (p_tx_period) else $error("tx strobe period");
	property p_rx_hold;
		!$stable(rx_data) |-> rx_char_stb;
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx_data off strobe");
	property p_lock_keep;
		rx_aligned |=> rx_aligned;
	endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("alignment lost");
	property p_fill;
		rx_data_valid |-> fill >= 4'hA;
	endproperty
	a_fill: assert property (p_fill) else $error("valid before fill");
	property p_valid_rise;
		$rose(rx_data_valid) |-> rx_char_stb;
	endproperty
	a_valid_rise: assert property (p_valid_rise) else $error("valid off strobe");
	property p_valid_keep;
		rx_data_valid |=> rx_data_valid;
	endproperty
	a_valid_keep: assert property (p_valid_keep) else $error("valid dropped");
	property p_ready_fall;
		$fell(tx_ready) |-> $past(tx_valid);
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("ready fell idle");
	property p_lock_char;
		$rose(rx_aligned) |-> (rx_char_stb || $past(rx_char_stb)) && rx_data == TRS_ZERO;
	endproperty
	a_lock_char: assert property (p_lock_char) else $error("lock not at boundary");
	c_lock: cover property ($rose(rx_aligned));
	c_full: cover property (tx_valid && !tx_ready);
	c_valid: cover property ($rose(rx_data_valid));
endmodule : snf_chk
bind snf_line_coder snf_chk u_chk (.ref_clk, .rst_n, .tx_valid, .tx_ready, .tx_char_stb,
	.rx_char_stb, .rx_data, .rx_data_valid, .rx_aligned);
`default_nettype wire

// >>> testbench/snf_link_peer.sv
// Purpose: Far link end: cable loop from line output back to line input
// Assumes: Three bit times of cable delay
// Notes:   invert models a swapped cable pair
`timescale 1ns/1ns
`default_nettype none
module snf_link_peer (
	input wire logic ref_clk, // Bit clock
	input wire logic tx_line, // Line from the block
	input wire logic invert,  // Swap polarity
	output logic     rx_line  // Line to the block
);
	logic [2:0] pipe = 3'h0;
	always_ff @(posedge ref_clk) begin
		pipe <= {pipe[1:0], tx_line};
	end
	assign rx_line = pipe[2] ^ invert;
endmodule : snf_link_peer
`default_nettype wire

// >>> testbench/snf_line_coder_tb.sv
// Purpose: Loopback regression of the line coder
// Assumes: Polarity changed only under reset
// Notes:   Characters compared after first reference lock
`timescale 1ns/1ns
`default_nettype none
module snf_line_coder_tb
	import snf_pkg::*;
;
	logic       ref_clk  = 1'b0;
	logic       rst_n    = 1'b0;
	logic       tx_valid = 1'b0;
	logic       tx_mode8 = 1'b0;
	logic       invert   = 1'b0;
	logic [9:0] tx_data  = IDLE_CHAR;
	logic       tx_ready, tx_char_stb, tx_serial, rx_serial;
	logic       rx_char_stb, rx_data_valid, rx_aligned;
	logic [9:0] rx_data;
	logic [9:0] exp_q[$];
	int         errors = 0;
	int         comparisons = 0;
	bit         synced = 0;
	bit         armed = 0;
	snf_line_coder DUT (.ref_clk, .rst_n, .tx_valid, .tx_ready, .tx_data, .tx_mode8,
		.tx_char_stb, .tx_serial, .rx_serial, .rx_char_stb, .rx_data, .rx_data_valid,
		.rx_aligned);
	snf_link_peer PEER (.ref_clk, .tx_line(tx_serial), .invert, .rx_line(rx_serial));
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic compare(input string name, input logic [9:0] exp, input logic [9:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : compare
	task automatic print_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	task automatic send(input logic m8, input logic [9:0] d, input logic [9:0] e);
		@(negedge ref_clk);
		tx_mode8 = m8;
		tx_data = d;
		tx_valid = 1'b1;
		while (tx_ready !== 1'b1)
			@(negedge ref_clk);
		@(posedge ref_clk);
		if (armed)
			exp_q.push_back(e);
	endtask : send
	task automatic send_rand(input int n);
		logic [7:0] b;
		logic [9:0] w;
		repeat (n) begin
			b = 8'(1 + $urandom % 254);
			w = 10'(4 + $urandom % 1016);
			if ($urandom % 2)
				send(1'b1, {w[9:8], b}, {b, PAD_BITS});
			else
				send(1'b0, w, w);
		end
	endtask : send_rand
	task automatic run(input logic inv);
		@(negedge ref_clk);
		rst_n = 1'b0;
		tx_valid = 1'b0;
		invert = inv;
		armed = 0;
		synced = 0;
		exp_q.delete();
		repeat (6) @(negedge ref_clk);
		rst_n = 1'b1;
		send_rand(3);
		send(1'b0, TRS_ONES, 10'h0);
		send(1'b0, TRS_ZERO, 10'h0);
		send(1'b0, TRS_ZERO, 10'h0);
		armed = 1;
		send_rand(20);
		send(1'b1, 10'h0FF, TRS_ONES);
		send(1'b1, 10'h000, TRS_ZERO);
		send(1'b1, 10'h300, TRS_ZERO);
		send(1'b0, 10'h3FD, TRS_ONES);
		send(1'b0, 10'h001, TRS_ZERO);
		send(1'b0, 10'h002, TRS_ZERO);
		send_rand(20);
		@(negedge ref_clk);
		tx_valid = 1'b0;
		for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(negedge ref_clk);
		compare("lock", 10'h1, {9'h0, synced});
		compare("pending", 10'h0, 10'(exp_q.size()));
	endtask : run
	always @(negedge ref_clk) begin
		if (rst_n && rx_char_stb && rx_aligned) begin
			if (!synced)
				synced = (rx_data === TRS_ZERO);
			else if (exp_q.size() > 0) begin
				compare("rx_data", exp_q.pop_front(), rx_data);
				compare("rx_data_valid", 10'h1, {9'h0, rx_data_valid});
			end
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		print_verdict();
	end
	initial begin
		void'($urandom(85));
		run(1'b0);
		run(1'b1);
		print_verdict();
	end
endmodule : snf_line_coder_tb
`default_nettype wire
